// ---- rtl/aopc_pkg.sv ----
// Package for the audio output pin configuration block.
// Holds register offsets, field positions, reset values, function codes and carrier structs.
package aopc_pkg;

  // Register offsets on the control port
  localparam logic [7:0] SLOT_OFF_ADDR     = 8'h34;
  localparam logic [7:0] DENSITY_CTRL_ADDR = 8'h36;
  localparam logic [7:0] MARKER_BYTE_ADDR  = 8'h37;
  localparam logic [7:0] PIN0_FUNC_ADDR    = 8'h38;

  // Reset values
  localparam logic [7:0] SLOT_OFF_RST     = 8'h00;
  localparam logic [7:0] DENSITY_CTRL_RST = 8'h00;
  localparam logic [7:0] MARKER_BYTE_RST  = 8'h00;
  localparam logic [7:0] PIN0_FUNC_RST    = 8'h00;

  // Field positions in the pulse-density control and pin 0 function registers
  localparam int MARKER_INSERT_BIT = 4;
  localparam int MARKER_CH_LSB     = 2;
  localparam int DENSITY_SRC_LSB   = 0;
  localparam int FUNC_CODE_LSB     = 0;

  // Marker channel select codes
  localparam logic [1:0] MARKER_CH_BOTH  = 2'h0;
  localparam logic [1:0] MARKER_CH_LEFT  = 2'h1;
  localparam logic [1:0] MARKER_CH_RIGHT = 2'h2;

  // Density output source codes
  localparam logic [1:0] DENSITY_OFF    = 2'h0;
  localparam logic [1:0] DENSITY_LEFT   = 2'h1;
  localparam logic [1:0] DENSITY_RIGHT  = 2'h2;
  localparam logic [1:0] DENSITY_STEREO = 2'h3;

  // Multipurpose pin function codes
  localparam logic [4:0] FN_AUDIO_IN    = 5'h00;
  localparam logic [4:0] FN_MUTE_ADC0   = 5'h01;
  localparam logic [4:0] FN_MUTE_ADC1   = 5'h02;
  localparam logic [4:0] FN_MUTE_ADC2   = 5'h03;
  localparam logic [4:0] FN_MUTE_ADC3   = 5'h04;
  localparam logic [4:0] FN_MUTE_ADC01  = 5'h05;
  localparam logic [4:0] FN_MUTE_ADC23  = 5'h06;
  localparam logic [4:0] FN_MUTE_ADCALL = 5'h07;
  localparam logic [4:0] FN_MUTE_DAC0   = 5'h08;
  localparam logic [4:0] FN_MUTE_DAC1   = 5'h09;
  localparam logic [4:0] FN_MUTE_DACALL = 5'h0A;
  localparam logic [4:0] FN_BANK_SWITCH = 5'h0B;
  localparam logic [4:0] FN_COMPRESS    = 5'h0E;
  localparam logic [4:0] FN_DSP_BYPASS  = 5'h0F;
  localparam logic [4:0] FN_VOLUME_UP   = 5'h10;
  localparam logic [4:0] FN_VOLUME_DOWN = 5'h11;

  // Synchroniser depth for the multipurpose pin
  localparam int PIN_SYNC_STAGES = 2;

  typedef struct packed {
    logic [7:0] slot_off;
    logic [7:0] density_ctrl;
    logic [7:0] marker_byte;
    logic [7:0] pin0_func;
  } aopc_regs_s;

  typedef struct packed {
    logic [3:0] mute_adc;
    logic [1:0] mute_dac;
    logic       bank_switch;
    logic       compress_en;
    logic       dsp_bypass;
    logic       volume_up;
    logic       volume_down;
  } aopc_actions_s;

  typedef struct packed {
    logic [7:0] slot_data_en;
    logic [7:0] slot_drive;
    logic       density_on;
    logic       density_left_from_right;
    logic       density_right_from_right;
    logic       marker_left;
    logic       marker_right;
    logic [7:0] marker_byte;
  } aopc_stream_s;

endpackage

// ---- rtl/aopc_pin_sync.sv ----
// Multi-stage synchroniser for one asynchronous level.
// Assumes a single clock and an asynchronous active-high reset.
`timescale 1ns/10ps
module aopc_pin_sync #(
  parameter int STAGES = 2
) (
  input  wire logic sys_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic async_i,
  output logic      sync_o
);

  typedef struct packed {
    logic [STAGES-1:0] chain;
  } aopc_sync_state_s;

  aopc_sync_state_s state_q;
  aopc_sync_state_s state_d;

  always_comb begin
    state_d       = state_q;
    state_d.chain = {state_q.chain[STAGES-2:0], async_i};
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign sync_o = state_q.chain[STAGES-1];

endmodule // aopc_pin_sync

// ---- rtl/aopc_top.sv ----
// Audio output pin configuration: slot disables, pulse-density control, marker byte, pin 0 function.
// Assumes a simple byte-wide control port from the codec core and one 50 MHz clock.
// Register writes and reads are single-cycle strobes; the pin may change at any time.
`timescale 1ns/10ps
module aopc_top (
  input  wire logic                  sys_clk_i,
  input  wire logic                  sys_rst_i,
  // Control port
  input  wire logic [7:0]            reg_addr_i,
  input  wire logic [7:0]            reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic      [7:0]            reg_rdata_o,
  output logic                       reg_rvalid_o,
  // Serial port context from the core
  input  wire logic                  tdm_mode_i,
  input  wire logic                  idle_slot_tristate_i,
  // Multipurpose pin zero
  input  wire logic                  multipurpose_pin_zero_i,
  output logic                       serial_audio_input_o,
  output logic                       serial_audio_input_sel_o,
  output aopc_pkg::aopc_actions_s    pin_actions_o,
  // Slot and density stream controls
  output aopc_pkg::aopc_stream_s     stream_ctrl_o
);

  // Every output is a flop of this state; nothing reaches a port combinationally
  typedef struct packed {
    aopc_pkg::aopc_regs_s    regs;
    logic [7:0]              rdata;
    logic                    rvalid;
    logic                    audio_in;
    logic                    audio_sel;
    aopc_pkg::aopc_actions_s actions;
    aopc_pkg::aopc_stream_s  stream;
  } aopc_state_s;

  aopc_state_s state_q;
  aopc_state_s state_d;
  logic        pin_sync;

  // Action decode for one function code and a synchronised pin level
  function automatic aopc_pkg::aopc_actions_s decode_actions(input logic [4:0] code,
                                                             input logic       level);
    aopc_pkg::aopc_actions_s a;
    a = '0;
    if (level) begin
      unique case (code)
        aopc_pkg::FN_MUTE_ADC0:   a.mute_adc    = 4'h1;
        aopc_pkg::FN_MUTE_ADC1:   a.mute_adc    = 4'h2;
        aopc_pkg::FN_MUTE_ADC2:   a.mute_adc    = 4'h4;
        aopc_pkg::FN_MUTE_ADC3:   a.mute_adc    = 4'h8;
        aopc_pkg::FN_MUTE_ADC01:  a.mute_adc    = 4'h3;
        aopc_pkg::FN_MUTE_ADC23:  a.mute_adc    = 4'hC;
        aopc_pkg::FN_MUTE_ADCALL: a.mute_adc    = 4'hF;
        aopc_pkg::FN_MUTE_DAC0:   a.mute_dac    = 2'h1;
        aopc_pkg::FN_MUTE_DAC1:   a.mute_dac    = 2'h2;
        aopc_pkg::FN_MUTE_DACALL: a.mute_dac    = 2'h3;
        aopc_pkg::FN_BANK_SWITCH: a.bank_switch = 1'b1;
        aopc_pkg::FN_COMPRESS:    a.compress_en = 1'b1;
        aopc_pkg::FN_DSP_BYPASS:  a.dsp_bypass  = 1'b1;
        aopc_pkg::FN_VOLUME_UP:   a.volume_up   = 1'b1;
        aopc_pkg::FN_VOLUME_DOWN: a.volume_down = 1'b1;
        default:                  a = '0;
      endcase
    end
    return a;
  endfunction

  // Marker lanes as {left, right} for a channel select code
  // The reserved code inserts nothing rather than guessing a lane
  function automatic logic [1:0] marker_lanes(input logic [1:0] ch);
    logic [1:0] lanes;
    lanes = 2'h0;
    unique case (ch)
      aopc_pkg::MARKER_CH_BOTH:  lanes = 2'h3;
      aopc_pkg::MARKER_CH_LEFT:  lanes = 2'h2;
      aopc_pkg::MARKER_CH_RIGHT: lanes = 2'h1;
      default:                   lanes = 2'h0;
    endcase
    return lanes;
  endfunction

  // Density source flags as {on, left lane from right, right lane from right}
  function automatic logic [2:0] source_flags(input logic [1:0] src);
    logic [2:0] flags;
    flags = 3'h0;
    unique case (src)
      aopc_pkg::DENSITY_OFF:    flags = 3'h0;
      aopc_pkg::DENSITY_LEFT:   flags = 3'h4;
      aopc_pkg::DENSITY_RIGHT:  flags = 3'h7;
      aopc_pkg::DENSITY_STEREO: flags = 3'h5;
    endcase
    return flags;
  endfunction

  // Read multiplexer; unmapped addresses read as zero so a probe never sees stale data
  function automatic logic [7:0] read_mux(input logic [7:0]           addr,
                                          input aopc_pkg::aopc_regs_s regs);
    logic [7:0] value;
    value = 8'h00;
    unique case (addr)
      aopc_pkg::SLOT_OFF_ADDR:     value = regs.slot_off;
      aopc_pkg::DENSITY_CTRL_ADDR: value = regs.density_ctrl;
      aopc_pkg::MARKER_BYTE_ADDR:  value = regs.marker_byte;
      aopc_pkg::PIN0_FUNC_ADDR:    value = regs.pin0_func;
      default:                     value = 8'h00;
    endcase
    return value;
  endfunction

  // Pin is taken through a synchroniser before any decode
  aopc_pin_sync #(
    .STAGES (aopc_pkg::PIN_SYNC_STAGES)
  ) u_pin_sync (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (multipurpose_pin_zero_i),
    .sync_o    (pin_sync)
  );

  always_comb begin
    logic [4:0] fn_code;
    logic [1:0] marker_ch;
    logic [1:0] src;
    logic [7:0] slot_mask;
    fn_code   = '0;
    marker_ch = '0;
    src       = '0;
    slot_mask = '0;
    state_d   = state_q;

    // Register writes; unmapped addresses are ignored
    // Reserved bits [7:5] are kept as written so read-back matches what software stored
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        aopc_pkg::SLOT_OFF_ADDR:     state_d.regs.slot_off     = reg_wdata_i;
        aopc_pkg::DENSITY_CTRL_ADDR: state_d.regs.density_ctrl = reg_wdata_i;
        aopc_pkg::MARKER_BYTE_ADDR:  state_d.regs.marker_byte  = reg_wdata_i;
        aopc_pkg::PIN0_FUNC_ADDR:    state_d.regs.pin0_func    = reg_wdata_i;
        default: ;
      endcase
    end

    // Register reads answer one cycle later; unmapped reads as zero
    state_d.rvalid = reg_rd_i;
    if (reg_rd_i) begin
      state_d.rdata = read_mux(reg_addr_i, state_q.regs);
    end

    // Slot gating applies only in TDM mode
    // Outside TDM the mask is ignored, so a mask left from TDM cannot silence a stereo channel
    slot_mask = tdm_mode_i ? state_q.regs.slot_off : 8'h00;
    state_d.stream.slot_data_en = ~slot_mask;
    state_d.stream.slot_drive   = idle_slot_tristate_i ? ~slot_mask
                                                       : 8'hFF;

    // Density output source
    src = state_q.regs.density_ctrl[aopc_pkg::DENSITY_SRC_LSB +: 2];
    {state_d.stream.density_on,
     state_d.stream.density_left_from_right,
     state_d.stream.density_right_from_right} = source_flags(src);

    // Marker insertion, only while the density output runs
    marker_ch = state_q.regs.density_ctrl[aopc_pkg::MARKER_CH_LSB +: 2];
    state_d.stream.marker_left  = 1'b0;
    state_d.stream.marker_right = 1'b0;
    if (state_q.regs.density_ctrl[aopc_pkg::MARKER_INSERT_BIT] && (src != aopc_pkg::DENSITY_OFF)) begin
      {state_d.stream.marker_left, state_d.stream.marker_right} = marker_lanes(marker_ch);
    end
    state_d.stream.marker_byte = state_q.regs.marker_byte;

    // Pin zero role
    // Actions follow the synchronised level, so a press shows three clocks late and never glitches
    fn_code           = state_q.regs.pin0_func[aopc_pkg::FUNC_CODE_LSB +: 5];
    state_d.audio_sel = (fn_code == aopc_pkg::FN_AUDIO_IN);
    state_d.audio_in  = state_d.audio_sel & pin_sync;
    state_d.actions   = decode_actions(fn_code, pin_sync);
  end

  // Reset leaves pin zero as audio input and every slot enabled and driven
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q                   <= '0;
      state_q.regs.slot_off     <= aopc_pkg::SLOT_OFF_RST;
      state_q.regs.density_ctrl <= aopc_pkg::DENSITY_CTRL_RST;
      state_q.regs.marker_byte  <= aopc_pkg::MARKER_BYTE_RST;
      state_q.regs.pin0_func    <= aopc_pkg::PIN0_FUNC_RST;
      state_q.audio_sel         <= 1'b1;
      state_q.stream.slot_data_en <= 8'hFF;
      state_q.stream.slot_drive   <= 8'hFF;
    end else begin
      state_q <= state_d;
    end
  end

  assign reg_rdata_o              = state_q.rdata;
  assign reg_rvalid_o             = state_q.rvalid;
  assign serial_audio_input_o     = state_q.audio_in;
  assign serial_audio_input_sel_o = state_q.audio_sel;
  assign pin_actions_o            = state_q.actions;
  assign stream_ctrl_o            = state_q.stream;

endmodule // aopc_top

// ---- testbench/aopc_monitor.sv ----
// Checker for aopc_top: register port timing, stream gating and pin zero actions.
// Bound to every aopc_top instance below; sees only that module's ports.
`timescale 1ns/10ps
module aopc_monitor (
  input wire logic                    sys_clk_i,
  input wire logic                    sys_rst_i,
  input wire logic [7:0]              reg_addr_i,
  input wire logic [7:0]              reg_wdata_i,
  input wire logic                    reg_wr_i,
  input wire logic                    reg_rd_i,
  input wire logic [7:0]              reg_rdata_o,
  input wire logic                    reg_rvalid_o,
  input wire logic                    tdm_mode_i,
  input wire logic                    idle_slot_tristate_i,
  input wire logic                    multipurpose_pin_zero_i,
  input wire logic                    serial_audio_input_o,
  input wire logic                    serial_audio_input_sel_o,
  input wire aopc_pkg::aopc_actions_s pin_actions_o,
  input wire aopc_pkg::aopc_stream_s  stream_ctrl_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  chk_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("no rvalid after read");
  chk_rvalid_single: assert property (!reg_rd_i |=> !reg_rvalid_o)
    else $error("rvalid without read");
  chk_rdata_holds: assert property (!reg_rvalid_o |-> $stable(reg_rdata_o))
    else $error("read data moved without read");
  chk_marker_write: assert property (reg_wr_i && reg_addr_i == aopc_pkg::MARKER_BYTE_ADDR
    |-> ##2 stream_ctrl_o.marker_byte == $past(reg_wdata_i, 2)) else $error("marker byte not applied");
  chk_slot_stereo: assert property (!tdm_mode_i |=> stream_ctrl_o.slot_data_en == 8'hFF)
    else $error("slot disabled outside tdm mode");
  chk_slot_driven: assert property (!idle_slot_tristate_i |=> stream_ctrl_o.slot_drive == 8'hFF)
    else $error("idle slot released while drive selected");
  chk_slot_tristate: assert property (idle_slot_tristate_i
    |=> stream_ctrl_o.slot_drive == stream_ctrl_o.slot_data_en) else $error("idle slot still driven");
  chk_marker_gate: assert property (!stream_ctrl_o.density_on
    |-> !(stream_ctrl_o.marker_left || stream_ctrl_o.marker_right)) else $error("marker with output off");
  chk_src_right: assert property (stream_ctrl_o.density_left_from_right
    |-> stream_ctrl_o.density_right_from_right) else $error("right source split");
  chk_input_role: assert property (serial_audio_input_sel_o |-> pin_actions_o == '0)
    else $error("action while pin is audio input");
  chk_pin_sync: assert property (pin_actions_o != '0 |-> $past(multipurpose_pin_zero_i, 3))
    else $error("action without synchronised pin");

  cover property (reg_rvalid_o);
  cover property (pin_actions_o != '0);
  cover property (stream_ctrl_o.marker_left && stream_ctrl_o.marker_right);
endmodule // aopc_monitor

bind aopc_top aopc_monitor u_aopc_monitor (.*);

// ---- testbench/aopc_button_model.sv ----
// Push-button on multipurpose pin zero; follows the press request after LAG clocks.
// Assumes the bench asks for presses as levels; the pin is always driven.
`timescale 1ns/10ps
module aopc_button_model #(
  parameter int LAG = 1
) (
  input  wire logic sys_clk_i,
  input  wire logic press_i,
  output logic      pin_o
);
  logic [7:0] pipe_q = 8'h00;
  always @(posedge sys_clk_i) begin
    pipe_q <= {pipe_q[6:0], press_i};
  end
  assign pin_o = pipe_q[LAG-1];
endmodule // aopc_button_model

// ---- testbench/tb.sv ----
// Self-checking bench for aopc_top: register port, slot and density controls, pin zero roles.
// Assumes the button model drives pin zero and the checker is bound to the design.
`timescale 1ns/10ps
module tb;
  logic                    sys_clk_i = 1'b0;
  logic                    sys_rst_i = 1'b1;
  logic [7:0]              reg_addr_i = 8'h00;
  logic [7:0]              reg_wdata_i = 8'h00;
  logic                    reg_wr_i = 1'b0;
  logic                    reg_rd_i = 1'b0;
  logic                    tdm_mode_i = 1'b0;
  logic                    idle_slot_tristate_i = 1'b0;
  logic                    press = 1'b0;
  logic                    pin;
  logic [7:0]              reg_rdata_o;
  logic                    reg_rvalid_o;
  logic                    serial_audio_input_o;
  logic                    serial_audio_input_sel_o;
  aopc_pkg::aopc_actions_s pin_actions_o;
  aopc_pkg::aopc_stream_s  stream_ctrl_o;
  logic [7:0]              exp_q[$];
  logic [7:0]              d;
  logic [7:0]              addrs[4] = '{8'h34, 8'h37, 8'h38, 8'h36};
  logic [10:0]             act;
  int                      n_fail = 0;
  int                      checks_done = 0;
  int                      cycles = 0;
  int                      seed = 32'hace0d9aa;

  always #10 sys_clk_i = ~sys_clk_i;

  aopc_top u_aopc_top (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .tdm_mode_i(tdm_mode_i), .idle_slot_tristate_i(idle_slot_tristate_i),
    .multipurpose_pin_zero_i(pin), .serial_audio_input_o(serial_audio_input_o),
    .serial_audio_input_sel_o(serial_audio_input_sel_o), .pin_actions_o(pin_actions_o),
    .stream_ctrl_o(stream_ctrl_o));
  aopc_button_model #(.LAG(2)) u_aopc_button_model (.sys_clk_i(sys_clk_i), .press_i(press), .pin_o(pin));

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge sys_clk_i);
    reg_addr_i = a;
    reg_wdata_i = v;
    reg_wr_i = 1'b1;
    @(negedge sys_clk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    exp_q.push_back(e);
    @(negedge sys_clk_i);
    reg_rd_i = 1'b0;
  endtask
  function automatic logic [10:0] exp_act(input logic [4:0] c);
    case (c)
      5'h01, 5'h02, 5'h03, 5'h04: return 11'h001 << (c + 5'h06);
      5'h05: return 11'h180;
      5'h06: return 11'h600;
      5'h07: return 11'h780;
      5'h08: return 11'h020;
      5'h09: return 11'h040;
      5'h0A: return 11'h060;
      5'h0B: return 11'h010;
      5'h0E: return 11'h008;
      5'h0F: return 11'h004;
      5'h10: return 11'h002;
      5'h11: return 11'h001;
      default: return 11'h000;
    endcase
  endfunction

  // Read answers are matched against notes in issue order
  always @(negedge sys_clk_i) begin
    if (reg_rvalid_o === 1'b1) begin
      if (exp_q.size() == 0) cmp("rvalid", 32'h0, 32'h1);
      else cmp("reg_rdata_o", {24'h0, exp_q.pop_front()}, {24'h0, reg_rdata_o});
    end
  end
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    idle(10);
    sys_rst_i = 1'b0;
    cmp("stream reset", {8'hFF, 8'hFF, 13'h0}, stream_ctrl_o);
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    foreach (addrs[i]) begin
      d = $random(seed);
      wr(addrs[i], d);
      rd(addrs[i], d);
    end
    wr(8'h35, 8'hFF);
    rd(8'h35, 8'h00);
    wr(aopc_pkg::DENSITY_CTRL_ADDR, 8'h00);
    d = $random(seed);
    wr(aopc_pkg::MARKER_BYTE_ADDR, d);
    idle(2);
    cmp("marker_byte", d, stream_ctrl_o.marker_byte);
    wr(aopc_pkg::SLOT_OFF_ADDR, d);
    for (int m = 0; m < 4; m++) begin
      tdm_mode_i = m[0];
      idle_slot_tristate_i = m[1];
      idle(2);
      cmp("slot_data_en", {24'h0, m[0] ? ~d : 8'hFF}, {24'h0, stream_ctrl_o.slot_data_en});
      cmp("slot_drive", {24'h0, m[0] && m[1] ? ~d : 8'hFF}, {24'h0, stream_ctrl_o.slot_drive});
    end
    for (int k = 0; k < 32; k++) begin
      wr(aopc_pkg::DENSITY_CTRL_ADDR, 8'h00);
      wr(aopc_pkg::DENSITY_CTRL_ADDR, k[7:0]);
      idle(2);
      cmp("density", {k[1:0] != 0, k[1:0] == 2, k[1], k[4] && k[1:0] != 0 && k[3:2] < 2,
        k[4] && k[1:0] != 0 && (k[3:2] == 0 || k[3:2] == 2)}, stream_ctrl_o[12:8]);
    end
    for (int c = 0; c < 19; c++) begin
      d = $random(seed);
      wr(aopc_pkg::PIN0_FUNC_ADDR, {d[7:5], c[4:0]});
      idle(2);
      press = 1'b1;
      idle(6);
      act = exp_act(c[4:0]);
      cmp("pin_actions_o", act, pin_actions_o);
      cmp("audio input", {c == 0, c == 0}, {serial_audio_input_o, serial_audio_input_sel_o});
      press = 1'b0;
      idle(6);
      cmp("pin released", 11'h000, pin_actions_o);
    end
    sys_rst_i = 1'b1;
    idle(2);
    sys_rst_i = 1'b0;
    rd(aopc_pkg::PIN0_FUNC_ADDR, 8'h00);
    idle(3);
    give_verdict();
  end
endmodule // tb
